/* File: shared/ocst_pkg.sv */
// package: constants and types of the overcurrent stage timing block
package ocst_pkg;
  // =====================================================
  // sizes and time base
  localparam int NSTG = 4;
  localparam int TICK_MS = 5;
  localparam int K_SCALE = 100;
  localparam int REL_DEFAULT_MS = 60;
  localparam logic [15:0] REL_TICKS = 16'(REL_DEFAULT_MS / TICK_MS);
  // =====================================================
  // curve constants, milli units
  localparam int RI_A_MILLI = 339;
  localparam int RI_B_MILLI = 236;
  localparam int RD_A_MILLI = 5800;
  localparam int RD_B_MILLI = 1350;
  localparam int LN2_MILLI = 693;
  localparam int RD_LOG2_MS = RD_B_MILLI * LN2_MILLI / 1000;
  localparam int RI_TICK_SCALE = 1000000 / (K_SCALE * TICK_MS);
  localparam int RESET_PCT = 97;
  // =====================================================
  // register map
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_SET = 8'h04;
  localparam logic [7:0] OFF_TIME = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0c;
  localparam logic [7:0] OFF_FORCE = 8'h40;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h44;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h48;
  // ctrl fields
  localparam int CTRL_EN = 0;
  localparam int CTRL_CURVE = 1;
  localparam int CTRL_MAG = 3;
  localparam int CTRL_DLY_REL = 5;
  localparam int CTRL_RST_AFTER = 6;
  localparam int CTRL_CONT = 7;
  localparam int CTRL_FSEL = 8;
  localparam int CTRL_FPH = 10;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0060;
  localparam logic [31:0] SET_RESET = 32'h0064_0078;
  localparam logic [31:0] TIME_RESET = {16'h0014, REL_TICKS};
  // =====================================================
  // enumerations and carriers
  typedef enum logic [1:0] {CURVE_DEFINITE, CURVE_MECH, CURVE_LOG} ocst_curve_t;
  typedef enum logic [1:0] {FORCE_NORMAL, FORCE_START, FORCE_TRIP, FORCE_BLOCKED} ocst_force_t;
  typedef enum logic [1:0] {ST_IDLE, ST_PICKED, ST_RELEASE} ocst_phase_t;

  typedef struct packed {
    logic valid;
    logic [2:0][2:0][15:0] mag; // [kind: fund, true_rms_magnitude, pp][phase c..a]
  } ocst_meas_t;

  typedef struct packed {
    ocst_phase_t st;
    logic [2:0] pu;
    logic [2:0] fph;
    logic [15:0] opcnt;
    logic [15:0] relcnt;
    logic [15:0] dly;
    logic start;
    logic trip;
    logic [2:0] start_ph;
    logic [2:0] trip_ph;
  } ocst_stage_t;

  typedef struct packed {
    ocst_stage_t [NSTG-1:0] stg;
    logic [NSTG-1:0][31:0] ctrl;
    logic [NSTG-1:0][31:0] set;
    logic [NSTG-1:0][31:0] tim;
    logic force_en;
    logic [7:0] irq_stat;
    logic [7:0] irq_mask;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ocst_state_t;
endpackage

/* File: hdl/ocst_timing.sv */
// four overcurrent stages: pick-up, inverse delay, release timer, forcing, apb registers
// Summary of operation
// - mechanical curve delay is dial over (0.339 minus 0.236 times setting over current)
// - log curve delay is 5.8 minus 1.35 times ln(current over dial times setting)
// - a negative log curve delay means instant operation
// - curves use the highest of the three monitored phase magnitudes
// - the non-standard curves are selectable per stage beside definite time
// - delayed release holds start for the release delay; otherwise start clears at once
// - release delay counts in 5 ms steps, 60 ms after reset
// - counter clears after release expiry if option set, else when pick-up drops
// - continue option keeps the operating counter running during release
// - during release no trip is issued unless pick-up returns
// - after reset release is delayed 60 ms with the counter held
// - with forcing enabled software may force normal, start, trip, blocked per stage; forced start and trip go to the selected phases
// - forced start and trip combine with the measured behaviour, forced blocked overrides it; disable forcing after tests
// - four independent stages, each with its own settings and timers
// - any single phase, any pair or all three phases pick up a stage
// - monitored magnitude is fundamental, true rms or peak-to-peak
// - pick-up above the setting, drop-out below 97 % of it
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ns
module ocst_timing (
  input wire logic pclk, // apb clock, 100 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire ocst_pkg::ocst_meas_t meas, // magnitudes with 5 ms strobe
  output logic [3:0] start, // per-stage start
  output logic [3:0] trip, // per-stage trip
  output logic [3:0][2:0] start_ph, // per-stage started phases
  output logic [3:0][2:0] trip_ph, // per-stage tripped phases
  output logic irq // level interrupt
);
  // =====================================================
  // arithmetic helpers
  // log2 in q.8, linear mantissa; good to about 1 % in the delay
  function automatic logic [12:0] log2q(input logic [31:0] x);
    logic [4:0] e;
    logic [31:0] n;
    e = 5'h0;
    n = 32'h0;
    for (int i = 0; i < 32; i++) begin
      if (x[i]) begin
        e = 5'(i);
      end
    end
    n = x << (5'h1f - e);
    return {e, n[30:23]};
  endfunction

  function automatic logic [15:0] max3(input logic [2:0][15:0] m);
    logic [15:0] r;
    r = m[0];
    for (int p = 1; p < 3; p++) begin
      if (m[p] > r) begin
        r = m[p];
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] sat16(input logic signed [39:0] v);
    logic [15:0] r;
    if (v < 0) begin
      r = 16'h0;
    end else if (v > 40'sh00_0000_ffff) begin
      r = 16'hffff;
    end else begin
      r = v[15:0];
    end
    return r;
  endfunction

  function automatic logic [15:0] calc_delay(input logic [1:0] curve, input logic [15:0] im,
      input logic [15:0] iset, input logic [15:0] k, input logic [15:0] dt);
    logic [31:0] ratio;
    logic [31:0] den;
    logic signed [13:0] l8;
    logic signed [39:0] ms;
    logic [15:0] r;
    ratio = 32'h0;
    den = 32'h1;
    l8 = 14'sh0;
    ms = 40'sh0;
    r = dt;
    case (curve)
      ocst_pkg::CURVE_MECH: begin
        ratio = (32'(ocst_pkg::RI_B_MILLI) * 32'(iset)) / 32'((im == 16'h0) ? 16'h1 : im);
        if (32'(ocst_pkg::RI_A_MILLI) > ratio) begin
          den = 32'(ocst_pkg::RI_A_MILLI) - ratio;
        end
        r = sat16(40'(32'(k) * 32'(ocst_pkg::RI_TICK_SCALE) / den));
      end
      ocst_pkg::CURVE_LOG: begin
        l8 = $signed({1'b0, log2q(32'(im) * 32'(ocst_pkg::K_SCALE))})
           - $signed({1'b0, log2q(32'(k) * 32'(iset))});
        ms = 40'(ocst_pkg::RD_A_MILLI)
           - ((40'(ocst_pkg::RD_LOG2_MS) * 40'(l8)) >>> 8);
        r = sat16(ms / 40'(ocst_pkg::TICK_MS));
      end
      default: r = dt;
    endcase
    return r;
  endfunction

  // =====================================================
  // state
  ocst_pkg::ocst_state_t q;
  ocst_pkg::ocst_state_t next_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int s = 0; s < ocst_pkg::NSTG; s++) begin
        q.stg[s] <= '0;
        q.ctrl[s] <= ocst_pkg::CTRL_RESET;
        q.set[s] <= ocst_pkg::SET_RESET;
        q.tim[s] <= ocst_pkg::TIME_RESET;
      end
      q.force_en <= 1'b0;
      q.irq_stat <= 8'h0;
      q.irq_mask <= 8'h0;
      q.irq <= 1'b0;
      q.prdata <= 32'h0;
      q.pready <= 1'b0;
      q.pslverr <= 1'b0;
    end else begin
      q <= next_q;
    end
  end

  // =====================================================
  // next state
  always_comb begin
    logic [31:0] c;
    logic [15:0] iset;
    logic [15:0] rel;
    logic [15:0] mag;
    logic [1:0] ksel;
    logic [2:0] fph;
    logic any;
    logic go;
    logic [7:0] ev;
    logic [1:0] si;
    logic hit;
    logic [31:0] rd;
    ocst_pkg::ocst_stage_t s;
    c = 32'h0;
    iset = 16'h0;
    rel = 16'h0;
    mag = 16'h0;
    ksel = 2'h0;
    fph = 3'h0;
    any = 1'b0;
    go = 1'b0;
    ev = 8'h0;
    si = paddr[5:4];
    hit = 1'b0;
    rd = 32'h0;
    s = '0;
    next_q = q;

    // stage timing, each stage on its own settings
    for (int n = 0; n < ocst_pkg::NSTG; n++) begin
      s = q.stg[n];
      c = q.ctrl[n];
      iset = q.set[n][15:0];
      rel = q.tim[n][15:0];
      ksel = (c[ocst_pkg::CTRL_MAG +: 2] == 2'h3) ? 2'h0 : c[ocst_pkg::CTRL_MAG +: 2];
      if (meas.valid) begin
        for (int p = 0; p < 3; p++) begin
          mag = meas.mag[ksel][p];
          if (mag > iset) begin
            s.pu[p] = 1'b1;
          end else if (32'(mag) * 32'd100 < 32'(iset) * 32'(ocst_pkg::RESET_PCT)) begin
            s.pu[p] = 1'b0;
          end
        end
        s.dly = calc_delay(c[ocst_pkg::CTRL_CURVE +: 2], max3(meas.mag[ksel]), iset,
                           q.set[n][31:16], q.tim[n][31:16]);
      end
      any = |s.pu;
      if (!c[ocst_pkg::CTRL_EN]) begin
        s = '0;
      end else if (meas.valid) begin
        unique case (q.stg[n].st)
          ocst_pkg::ST_IDLE: begin
            s.fph = 3'h0;
            if (any) begin
              s.st = ocst_pkg::ST_PICKED;
              s.fph = s.pu;
              s.opcnt = 16'h1;
            end
          end
          ocst_pkg::ST_PICKED: begin
            if (any) begin
              s.fph = q.stg[n].fph | s.pu;
              if (s.opcnt != 16'hffff) begin
                s.opcnt = s.opcnt + 16'h1;
              end
            end else if (c[ocst_pkg::CTRL_DLY_REL] || c[ocst_pkg::CTRL_RST_AFTER]) begin
              s.st = ocst_pkg::ST_RELEASE;
              s.relcnt = 16'h1;
              if (!c[ocst_pkg::CTRL_RST_AFTER]) begin
                s.opcnt = 16'h0;
              end
              if (rel <= 16'h1) begin
                s.st = ocst_pkg::ST_IDLE;
                s.opcnt = 16'h0;
              end
            end else begin
              s.st = ocst_pkg::ST_IDLE;
              s.opcnt = 16'h0;
            end
          end
          ocst_pkg::ST_RELEASE: begin
            if (any) begin
              s.st = ocst_pkg::ST_PICKED;
              s.fph = s.pu;
              s.relcnt = 16'h0;
              if (s.opcnt != 16'hffff) begin
                s.opcnt = s.opcnt + 16'h1;
              end
            end else begin
              s.relcnt = s.relcnt + 16'h1;
              if (c[ocst_pkg::CTRL_CONT] && s.opcnt != 16'hffff) begin
                s.opcnt = s.opcnt + 16'h1;
              end
              if (s.relcnt >= rel) begin
                s.st = ocst_pkg::ST_IDLE;
                s.opcnt = 16'h0;
                s.relcnt = 16'h0;
              end
            end
          end
          default: s.st = ocst_pkg::ST_IDLE;
        endcase
      end
      // measured outputs; trip only while picked up
      go = (s.st == ocst_pkg::ST_PICKED) && (s.opcnt >= s.dly);
      s.start = (s.st == ocst_pkg::ST_PICKED)
             || (s.st == ocst_pkg::ST_RELEASE && c[ocst_pkg::CTRL_DLY_REL]);
      s.trip = go;
      s.start_ph = s.start ? s.fph : 3'h0;
      s.trip_ph = go ? s.fph : 3'h0;
      // forcing adds to measured behaviour, except blocked
      if (q.force_en) begin
        fph = (c[ocst_pkg::CTRL_FPH +: 3] == 3'h0) ? 3'h7 : c[ocst_pkg::CTRL_FPH +: 3];
        unique case (c[ocst_pkg::CTRL_FSEL +: 2])
          ocst_pkg::FORCE_START: begin
            s.start = 1'b1;
            s.start_ph = s.start_ph | fph;
          end
          ocst_pkg::FORCE_TRIP: begin
            s.start = 1'b1;
            s.trip = 1'b1;
            s.start_ph = s.start_ph | fph;
            s.trip_ph = s.trip_ph | fph;
          end
          ocst_pkg::FORCE_BLOCKED: begin
            s.start = 1'b0;
            s.trip = 1'b0;
            s.start_ph = 3'h0;
            s.trip_ph = 3'h0;
          end
          default: s.start = s.start;
        endcase
      end
      ev[n] = s.start && !q.stg[n].start;
      ev[n + 4] = s.trip && !q.stg[n].trip;
      next_q.stg[n] = s;
    end

    // =====================================================
    // apb slave: ready in the first access cycle
    next_q.pready = 1'b0;
    next_q.pslverr = 1'b0;
    if (psel && !penable) begin
      next_q.pready = 1'b1;
      hit = 1'b1;
      if (!paddr[6] && !paddr[7]) begin
        unique case ({paddr[3:2], 2'b00})
          ocst_pkg::OFF_CTRL[3:0]: rd = q.ctrl[si];
          ocst_pkg::OFF_SET[3:0]: rd = q.set[si];
          ocst_pkg::OFF_TIME[3:0]: rd = q.tim[si];
          default: rd = {q.stg[si].opcnt, 6'h0, q.stg[si].st, q.stg[si].trip_ph,
                         q.stg[si].start_ph, q.stg[si].trip, q.stg[si].start};
        endcase
      end else if (paddr == ocst_pkg::OFF_FORCE) begin
        rd = {31'h0, q.force_en};
      end else if (paddr == ocst_pkg::OFF_IRQ_STAT) begin
        rd = {24'h0, q.irq_stat};
      end else if (paddr == ocst_pkg::OFF_IRQ_MASK) begin
        rd = {24'h0, q.irq_mask};
      end else begin
        hit = 1'b0;
      end
      next_q.pslverr = !hit || (paddr[1:0] != 2'h0);
      next_q.prdata = (hit && !pwrite) ? rd : 32'h0;
    end
    if (psel && penable && q.pready && !q.pslverr) begin
      if (pwrite) begin
        if (!paddr[6] && !paddr[7]) begin
          unique case ({paddr[3:2], 2'b00})
            ocst_pkg::OFF_CTRL[3:0]: next_q.ctrl[si] = pwdata;
            ocst_pkg::OFF_SET[3:0]: next_q.set[si] = pwdata;
            ocst_pkg::OFF_TIME[3:0]: next_q.tim[si] = pwdata;
            default: next_q.prdata = q.prdata;
          endcase
        end else if (paddr == ocst_pkg::OFF_FORCE) begin
          next_q.force_en = pwdata[0];
        end else if (paddr == ocst_pkg::OFF_IRQ_MASK) begin
          next_q.irq_mask = pwdata[7:0];
        end
      end else if (paddr == ocst_pkg::OFF_IRQ_STAT) begin
        next_q.irq_stat = 8'h0;
      end
    end
    // new events win over a read-clear in the same cycle
    next_q.irq_stat = next_q.irq_stat | ev;
    next_q.irq = |(next_q.irq_stat & next_q.irq_mask);
  end

  // =====================================================
  // outputs straight from flops
  always_comb begin
    for (int n = 0; n < ocst_pkg::NSTG; n++) begin
      start[n] = q.stg[n].start;
      trip[n] = q.stg[n].trip;
      start_ph[n] = q.stg[n].start_ph;
      trip_ph[n] = q.stg[n].trip_ph;
    end
  end
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign irq = q.irq;
endmodule

/* File: dv/ocst_meas_model.sv */
// front-end model: per-phase magnitudes with a periodic valid strobe
`timescale 1ns/1ns
module ocst_meas_model #(
  parameter int TP = 8 // cycles per tick, shortened from 5 ms
) (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic [2:0][2:0][15:0] lvl, // magnitudes to present
  output ocst_pkg::ocst_meas_t meas // strobed samples
);
  int cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      meas <= '0;
    end else begin
      cnt <= (cnt == TP - 1) ? 0 : cnt + 1;
      meas.valid <= (cnt == TP - 1);
      // junk between strobes, so a stale sample can never pass
      meas.mag <= (cnt == TP - 1) ? lvl : ~lvl;
    end
  end
endmodule

/* File: dv/ocst_timing_chk.sv */
// checker: port-level timing of the overcurrent stage block
`timescale 1ns/1ns
module ocst_timing_chk (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire ocst_pkg::ocst_meas_t meas, // samples
  input wire logic [3:0] start, // stage start
  input wire logic [3:0] trip, // stage trip
  input wire logic [3:0][2:0] start_ph, // start phases
  input wire logic [3:0][2:0] trip_ph, // trip phases
  input wire logic irq // interrupt
);
  logic wr;
  logic acc;
  assign wr = psel && penable && pwrite && pready;
  assign acc = psel && penable && pready;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // =====================================
  // bus
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error without ready or with data");
  a_write_zero: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("read data on a write");
  // =====================================
  // stage outputs
  a_start_cause: assert property ($changed(start) |-> $past(meas.valid) || $past(wr) || $past(wr, 2))
    else $error("start moved without tick or write");
  a_trip_cause: assert property ($rose(trip) |-> $past(meas.valid) || $past(wr) || $past(wr, 2))
    else $error("trip rose without tick or write");
  a_quiet_reset: assert property ($rose(presetn) |-> start == 4'h0 && trip == 4'h0 && !irq)
    else $error("outputs not clear after reset");
  // irq is registered in the same cycle as the stage event, so a tick shows one cycle back
  a_irq_cause: assert property ($rose(irq) |->
    $past(meas.valid) || $past(wr) || $past(wr, 2))
    else $error("irq rose without cause");
  a_irq_clear: assert property ($fell(irq) |-> $past(acc) || $past(acc, 2))
    else $error("irq fell without access");
  c_trip: cover property ($rose(trip[0]));
  c_err: cover property (pslverr);
  c_irq: cover property ($rose(irq));
endmodule
bind ocst_timing ocst_timing_chk ocst_timing_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .meas(meas), .start(start), .trip(trip),
  .start_ph(start_ph), .trip_ph(trip_ph), .irq(irq));

/* File: dv/test_ocst_timing.sv */
// testbench: curves, release options, pick-up, forcing, registers
`timescale 1ns/1ns
module test_ocst_timing;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq, er;
  ocst_pkg::ocst_meas_t meas;
  logic [3:0] start, trip;
  logic [3:0][2:0] start_ph, trip_ph;
  logic [2:0][2:0][15:0] lvl = '0;
  logic [31:0] rd;
  logic [2:0] ph;
  logic [31:0] rc[4] = '{32'h61, 32'he1, 32'h21, 32'h01};
  int rn[4] = '{4, 1, 6, 6};
  logic [15:0] hv[4] = '{16'd120, 16'd121, 16'd117, 16'd116};
  logic hs[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  int seed = 59900;
  int n, kd;
  always #5 pclk = ~pclk;
  ocst_timing ocst_timing_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .meas(meas), .start(start), .trip(trip), .start_ph(start_ph),
    .trip_ph(trip_ph), .irq(irq));
  ocst_meas_model #(.TP(8)) ocst_meas_model_i (.pclk(pclk), .presetn(presetn), .lvl(lvl),
    .meas(meas));
  // =====================================
  // reporting
  task automatic conclude();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      conclude();
    end
  end
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // =====================================
  // drivers
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) ck(32'h1, 32'h0);
  endtask
  task automatic tick(input int t);
    repeat (t) begin
      do @(posedge pclk); while (meas.valid !== 1'b1);
    end
    repeat (2) @(posedge pclk);
    #1;
  endtask
  task automatic rst();
    @(posedge pclk);
    presetn <= 1'b0;
    lvl <= '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  // ticks until stage 0 trips, within a tolerance for curve rounding
  task automatic upto(input int e, input int tol);
    n = 0;
    while (trip[0] !== 1'b1 && n < e + tol + 2) begin
      tick(1);
      n++;
    end
    ck((n >= e - tol && n <= e + tol) ? e : n, e);
  endtask
  function automatic int mech_t(real k, real ist, real im);
    return $rtoi(k / (0.339 - 0.236 * ist / im) * 200.0);
  endfunction
  function automatic int log_t(real k, real ist, real im);
    real t;
    t = 5.8 - 1.35 * $ln(im / (k * ist));
    return (t <= 0.0) ? 1 : $rtoi(t * 200.0);
  endfunction
  task automatic curve(input logic [31:0] c, input logic [31:0] s, input logic [15:0] im,
                       input int e, input int tol);
    rst();
    apb(1, 8'h04, s);
    apb(1, 8'h08, 32'h0004_000c);
    apb(1, 8'h00, c);
    lvl[0] <= {im, 16'd100, 16'd130};
    upto(e, tol);
  endtask
  // =====================================
  // scenarios
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 8'h00, 0);
    ck(rd, 32'h0000_0060);
    apb(0, 8'h04, 0);
    ck(rd, 32'h0064_0078);
    apb(0, 8'h38, 0);
    ck(rd, 32'h0014_000c);
    apb(0, 8'h50, 0);
    ck({rd[30:0], er}, 32'h1);
    apb(1, 8'h02, 32'hffff_ffff);
    ck({31'h0, er}, 32'h1);
    $display("registers done");
    curve(32'h61, 32'h0064_0078, 16'd200, 4, 0);
    curve(32'h63, 32'h000a_0078, 16'd240, mech_t(0.1, 120.0, 240.0), 2);
    curve(32'h65, 32'h0064_0078, 16'd240, log_t(1.0, 120.0, 240.0), 3);
    curve(32'h65, 32'h0005_0078, 16'd1200, log_t(0.05, 120.0, 1200.0), 0);
    $display("curves done");
    foreach (rc[i]) begin
      rst();
      apb(1, 8'h08, 32'h0006_0014);
      apb(1, 8'h00, rc[i]);
      lvl[0][0] <= 16'd200;
      tick(2);
      lvl[0][0] <= 16'd0;
      tick(10);
      ck(trip[0], 1'b0);
      ck(start[0], rc[i][5]);
      lvl[0][0] <= 16'd200;
      upto(rn[i], 0);
    end
    $display("release done");
    rst();
    apb(1, 8'h48, 32'h1);
    apb(1, 8'h00, 32'h01);
    foreach (hv[i]) begin
      lvl[0][1] <= hv[i];
      tick(1);
      ck(start[0], hs[i]);
      if (i == 1) begin
        ck(irq, 1'b1);
        ck(start_ph[0], 3'b010);
        apb(0, 8'h44, 0);
        ck(rd, 32'h1);
        repeat (2) @(posedge pclk);
        #1;
        ck(irq, 1'b0);
      end
    end
    $display("pick-up done");
    for (int i = 0; i < 6; i++) begin
      kd = ($random(seed) & 32'h7fff_ffff) % 3;
      ph = 3'(($random(seed) & 32'h7fff_ffff) % 7 + 1);
      rst();
      apb(1, 8'h00, 32'h01 | (32'(kd) << 3));
      for (int p = 0; p < 3; p++) begin
        lvl[kd][p] <= ph[p] ? 16'(130 + ($random(seed) & 32'h3ff)) : 16'($random(seed) & 32'h3f);
      end
      tick(1);
      ck(start_ph[0], ph);
    end
    $display("phases done");
    rst();
    apb(1, 8'h40, 32'h1);
    lvl[0][0] <= 16'd200;
    for (int m = 0; m < 4; m++) begin
      apb(1, 8'h10, 32'h61 | (32'(m) << 8));
      tick(1);
      if (m == 2) ck(trip[1], 1'b1);
      if (m == 2) ck(trip_ph[1], 3'h7);
      else ck(start[1], m != 3);
      ck(start[0], 1'b0);
    end
    apb(1, 8'h40, 32'h0);
    $display("forcing done");
    conclude();
  end
endmodule
